// ### hw/bgm_top.sv
// Bargraph meter controller: menu, calibration, scaling and register slave
//
// Local design decisions: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

module bgm_top #(
	parameter int TICK_CYCLES = bgm_pkg::TICK_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic btn_prog,
	input wire logic btn_up,
	input wire logic btn_down,
	input wire logic signed [15:0] signal_in,
	input wire logic analog_present,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output bgm_pkg::bgm_disp_t disp,
	output logic [15:0] dac_code
);
	localparam int DW = $clog2(TICK_CYCLES + 1);

	// ----------------------------------------
	// Millisecond tick and blink phase
	// ----------------------------------------
	logic [DW-1:0] div_cnt;
	logic tick;
	logic [7:0] blink_cnt;
	logic blink;

	// Every slow rate hangs off this one tick
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt <= '0;
			tick <= 1'b0;
		end else if (div_cnt == DW'(TICK_CYCLES - 1)) begin
			div_cnt <= '0;
			tick <= 1'b1;
		end else begin
			div_cnt <= div_cnt + 1'b1;
			tick <= 1'b0;
		end
	end

	// Label and flash phase
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			blink_cnt <= '0;
			blink <= 1'b0;
		end else if (tick) begin
			if (blink_cnt == 8'(bgm_pkg::BLINK_MS - 1)) begin
				blink_cnt <= '0;
				blink <= ~blink;
			end else begin
				blink_cnt <= blink_cnt + 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Buttons
	// ----------------------------------------
	wire [2:0] btn_raw = {btn_down, btn_up, btn_prog};
	wire [2:0] btn_stable;
	logic [2:0] seen;
	logic [2:0] gesture;
	logic gesture_vld;

	for (genvar i = 0; i < 3; i++) begin : g_deb
		logic stable;
		logic [4:0] cnt;
		// A level must hold a full debounce time to count
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				stable <= 1'b0;
				cnt <= '0;
			end else if (btn_raw[i] == stable) begin
				cnt <= '0;
			end else if (tick) begin
				if (cnt == 5'(bgm_pkg::DEBOUNCE_MS - 1)) begin
					stable <= btn_raw[i];
					cnt <= '0;
				end else begin
					cnt <= cnt + 1'b1;
				end
			end
		end
		assign btn_stable[i] = stable;
	end

	// Collect every button held during one press, act at full release
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			seen <= '0;
			gesture <= '0;
			gesture_vld <= 1'b0;
		end else if (btn_stable != 3'h0) begin
			seen <= seen | btn_stable;
			gesture_vld <= 1'b0;
		end else if (seen != 3'h0) begin
			gesture <= seen;
			gesture_vld <= 1'b1;
			seen <= '0;
		end else begin
			gesture_vld <= 1'b0;
		end
	end

	wire ev_prog = gesture_vld && gesture == 3'h1;
	wire ev_up = gesture_vld && gesture == 3'h2;
	wire ev_down = gesture_vld && gesture == 3'h4;
	wire ev_cal = gesture_vld && gesture == 3'h3;

	// ----------------------------------------
	// Stored settings and control
	// ----------------------------------------
	bgm_pkg::bgm_state_t state, next_state;
	logic signed [17:0] edit_val, next_edit;
	logic signed [17:0] cal_lo_sig, cal_hi_sig, cal_lo_rd, cal_hi_rd;
	logic signed [17:0] zero_sig, zero_rd;
	logic signed [17:0] bargraph_low, bargraph_high;
	logic signed [17:0] analog_low_digital_value, analog_high_value;
	logic signed [17:0] analog_low_calibration, analog_high_calibration;
	logic [1:0] decimal_point_select;
	logic [2:0] brightness_level;
	logic center_sel;
	logic [1:0] ctrl;
	logic cal_err;
	logic [13:0] ms_cnt;
	logic signed [17:0] reading;
	logic sig_over, dig_over;

	wire signed [17:0] sig_ext = 18'(signal_in);
	wire toggle_st = state inside {bgm_pkg::S_CAL, bgm_pkg::S_OUTSEL, bgm_pkg::S_CENTER};
	wire timed_st = state inside {bgm_pkg::S_CAL, bgm_pkg::S_OUTSEL, bgm_pkg::S_BAR_HI,
		bgm_pkg::S_BAR_LO, bgm_pkg::S_DEC, bgm_pkg::S_BRIGHT, bgm_pkg::S_AN_HI,
		bgm_pkg::S_AN_LO, bgm_pkg::S_CENTER};
	wire timed_out = timed_st && tick &&
		ms_cnt == 14'(bgm_pkg::TIMEOUT_MS - 1);
	wire lamp_done = tick && ms_cnt == 14'(bgm_pkg::LAMP_MS - 1);
	wire ver_done = tick && ms_cnt == 14'(bgm_pkg::VERSION_MS - 1);
	wire err_done = tick && ms_cnt == 14'(bgm_pkg::ERROR_MS - 1);

	// Two-point check: enough signal difference and a reachable scale
	logic signed [39:0] cal_ds, cal_dr;
	logic cal_ok;
	always_comb begin
		cal_ds = 40'(sig_ext) - 40'(zero_sig);
		cal_dr = 40'(edit_val) - 40'(zero_rd);
		if (cal_dr < 0)
			cal_dr = -cal_dr;
		cal_ok = cal_ds >= 40'(bgm_pkg::CAL_MIN_DIFF) &&
			cal_dr * 40'(bgm_pkg::SIG_WINDOW) <=
			cal_ds * 40'(bgm_pkg::DISP_SPAN);
	end

	// Edit range of the current step
	logic signed [17:0] e_min, e_max, e_step;
	always_comb begin
		e_min = 18'sh0;
		e_max = 18'sh1;
		e_step = 18'sh1;
		case (state)
			bgm_pkg::S_ZERO, bgm_pkg::S_SPAN, bgm_pkg::S_BAR_HI, bgm_pkg::S_BAR_LO,
			bgm_pkg::S_AN_HI, bgm_pkg::S_AN_LO: begin
				e_min = 18'(bgm_pkg::DISP_MIN);
				e_max = 18'(bgm_pkg::DISP_MAX);
			end
			bgm_pkg::S_DEC: e_max = 18'(bgm_pkg::DP_MAX);
			bgm_pkg::S_BRIGHT: begin
				e_min = 18'sh1;
				e_max = 18'(bgm_pkg::BRIGHT_MAX);
			end
			bgm_pkg::S_OUT_LOW, bgm_pkg::S_OUT_HIGH: begin
				e_max = 18'(bgm_pkg::DAC_MAX);
				e_step = 18'(bgm_pkg::DAC_STEP);
			end
			default: ;
		endcase
	end

	// Menu sequencing
	always_comb begin
		next_state = state;
		next_edit = edit_val;
		case (state)
			bgm_pkg::S_LAMP: if (lamp_done) next_state = bgm_pkg::S_VER;
			bgm_pkg::S_VER: if (ver_done) next_state = bgm_pkg::S_RUN;
			bgm_pkg::S_RUN: if (ev_cal && !ctrl[bgm_pkg::CTRL_LOCK_BIT])
				next_state = bgm_pkg::S_CAL;
			bgm_pkg::S_CAL: if (ev_prog) begin
				if (!edit_val[0])
					next_state = bgm_pkg::S_BAR_HI;
				else if (analog_present)
					next_state = bgm_pkg::S_OUTSEL;
				else
					next_state = bgm_pkg::S_ZERO;
			end
			bgm_pkg::S_OUTSEL: if (ev_prog)
				next_state = edit_val[0] ? bgm_pkg::S_OUT_LOW : bgm_pkg::S_ZERO;
			bgm_pkg::S_ZERO: if (ev_prog) next_state = bgm_pkg::S_SPAN;
			bgm_pkg::S_SPAN: if (ev_prog)
				next_state = cal_ok ? bgm_pkg::S_BAR_HI : bgm_pkg::S_ERR;
			bgm_pkg::S_ERR: if (err_done) next_state = bgm_pkg::S_RUN;
			bgm_pkg::S_BAR_HI: if (ev_prog) next_state = bgm_pkg::S_BAR_LO;
			bgm_pkg::S_BAR_LO: if (ev_prog) next_state = bgm_pkg::S_DEC;
			bgm_pkg::S_DEC: if (ev_prog) next_state = bgm_pkg::S_BRIGHT;
			bgm_pkg::S_BRIGHT: if (ev_prog)
				next_state = analog_present ? bgm_pkg::S_AN_HI : bgm_pkg::S_CENTER;
			bgm_pkg::S_AN_HI: if (ev_prog) next_state = bgm_pkg::S_AN_LO;
			bgm_pkg::S_AN_LO: if (ev_prog) next_state = bgm_pkg::S_CENTER;
			bgm_pkg::S_CENTER: if (ev_prog) next_state = bgm_pkg::S_RUN;
			bgm_pkg::S_OUT_LOW: if (ev_prog) next_state = bgm_pkg::S_OUT_HIGH;
			bgm_pkg::S_OUT_HIGH: if (ev_prog) next_state = bgm_pkg::S_RUN;
			default: next_state = bgm_pkg::S_RUN;
		endcase
		if (timed_out && !gesture_vld)
			next_state = bgm_pkg::S_RUN;
		if (next_state != state) begin
			case (next_state)
				bgm_pkg::S_ZERO: next_edit = cal_lo_rd;
				bgm_pkg::S_SPAN: next_edit = cal_hi_rd;
				bgm_pkg::S_BAR_HI: next_edit = bargraph_high;
				bgm_pkg::S_BAR_LO: next_edit = bargraph_low;
				bgm_pkg::S_DEC: next_edit = 18'(decimal_point_select);
				bgm_pkg::S_BRIGHT: next_edit = 18'(brightness_level);
				bgm_pkg::S_AN_HI: next_edit = analog_high_value;
				bgm_pkg::S_AN_LO: next_edit = analog_low_digital_value;
				bgm_pkg::S_OUT_LOW: next_edit = analog_low_calibration;
				bgm_pkg::S_OUT_HIGH: next_edit = analog_high_calibration;
				bgm_pkg::S_CENTER: next_edit = 18'(center_sel);
				default: next_edit = 18'sh0;
			endcase
		end else if (toggle_st && (ev_up || ev_down)) begin
			next_edit = {17'h0, ~edit_val[0]};
		end else if (ev_up) begin
			next_edit = (edit_val > e_max - e_step) ? e_max : edit_val + e_step;
		end else if (ev_down) begin
			next_edit = (edit_val < e_min + e_step) ? e_min : edit_val - e_step;
		end
	end

	// State and value under edit
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= bgm_pkg::S_LAMP;
			edit_val <= 18'sh0;
		end else begin
			state <= next_state;
			edit_val <= next_edit;
		end
	end

	// Step timer, restarted by each step and by any held button in a timed step
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			ms_cnt <= '0;
		else if (next_state != state || (timed_st && btn_stable != 3'h0))
			ms_cnt <= '0;
		else if (tick && ms_cnt != 14'(bgm_pkg::TIMEOUT_MS - 1))
			ms_cnt <= ms_cnt + 1'b1;
	end

	// Settings change only on a program press that leaves the step
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cal_lo_sig <= 18'(bgm_pkg::CAL_LO_SIG_RST);
			cal_hi_sig <= 18'(bgm_pkg::CAL_HI_SIG_RST);
			cal_lo_rd <= 18'(bgm_pkg::CAL_LO_RD_RST);
			cal_hi_rd <= 18'(bgm_pkg::CAL_HI_RD_RST);
			zero_sig <= 18'sh0;
			zero_rd <= 18'sh0;
			bargraph_low <= 18'(bgm_pkg::BAR_LO_RST);
			bargraph_high <= 18'(bgm_pkg::BAR_HI_RST);
			analog_low_digital_value <= 18'(bgm_pkg::AN_LO_RST);
			analog_high_value <= 18'(bgm_pkg::AN_HI_RST);
			analog_low_calibration <= 18'(bgm_pkg::OUT_LO_RST);
			analog_high_calibration <= 18'(bgm_pkg::OUT_HI_RST);
			decimal_point_select <= 2'h0;
			brightness_level <= 3'(bgm_pkg::BRIGHT_RST);
			center_sel <= 1'b0;
		end else if (ev_prog) begin
			case (state)
				bgm_pkg::S_ZERO: begin
					zero_sig <= sig_ext;
					zero_rd <= edit_val;
				end
				bgm_pkg::S_SPAN: if (cal_ok) begin
					cal_lo_sig <= zero_sig;
					cal_lo_rd <= zero_rd;
					cal_hi_sig <= sig_ext;
					cal_hi_rd <= edit_val;
				end
				bgm_pkg::S_BAR_HI: bargraph_high <= edit_val;
				bgm_pkg::S_BAR_LO: begin
					// Keep the bargraph span inside its legal range
					if (bargraph_high - edit_val < 18'(bgm_pkg::BAR_SPAN_MIN))
						bargraph_low <= bargraph_high - 18'(bgm_pkg::BAR_SPAN_MIN);
					else if (bargraph_high - edit_val > 18'(bgm_pkg::DISP_SPAN))
						bargraph_low <= bargraph_high - 18'(bgm_pkg::DISP_SPAN);
					else
						bargraph_low <= edit_val;
				end
				bgm_pkg::S_DEC: decimal_point_select <= edit_val[1:0];
				bgm_pkg::S_BRIGHT: brightness_level <= edit_val[2:0];
				bgm_pkg::S_AN_HI: analog_high_value <= edit_val;
				bgm_pkg::S_AN_LO: analog_low_digital_value <= edit_val;
				bgm_pkg::S_CENTER: center_sel <= edit_val[0];
				bgm_pkg::S_OUT_LOW: analog_low_calibration <= edit_val;
				bgm_pkg::S_OUT_HIGH: begin
					// High point must stay above the low point
					if (edit_val <= analog_low_calibration)
						analog_high_calibration <= analog_low_calibration + 18'sh1;
					else
						analog_high_calibration <= edit_val;
				end
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// Scaling
	// ----------------------------------------
	logic signed [39:0] rd_full, bar_num, an_den, an_full;
	logic [6:0] bars;
	logic bar_over;
	logic [15:0] next_dac;
	always_comb begin
		rd_full = (40'(sig_ext) - 40'(cal_lo_sig)) * (40'(cal_hi_rd) - 40'(cal_lo_rd)) /
			(40'(cal_hi_sig) - 40'(cal_lo_sig)) + 40'(cal_lo_rd);
		// Bars: span from low to high onto 101 segments
		bar_num = (40'(reading) - 40'(bargraph_low)) * 40'(bgm_pkg::BAR_SEGS);
		bar_over = 1'b0;
		if (reading < bargraph_low) begin
			bars = 7'h00;
		end else if (reading > bargraph_high) begin
			bars = 7'(bgm_pkg::BAR_SEGS);
			bar_over = 1'b1;
		end else begin
			bars = 7'(bar_num / (40'(bargraph_high) - 40'(bargraph_low)));
		end
		// Analog: a reversed pair gives a negative slope
		an_den = 40'(analog_high_value) - 40'(analog_low_digital_value);
		if (an_den == 40'sh0)
			an_den = 40'sh1;
		an_full = (40'(reading) - 40'(analog_low_digital_value)) *
			(40'(analog_high_calibration) - 40'(analog_low_calibration)) / an_den +
			40'(analog_low_calibration);
		if (an_full < 40'(analog_low_calibration))
			next_dac = analog_low_calibration[15:0];
		else if (an_full > 40'(bgm_pkg::DAC_MAX))
			next_dac = 16'hFFFF;
		else
			next_dac = an_full[15:0];
		if (state inside {bgm_pkg::S_OUT_LOW, bgm_pkg::S_OUT_HIGH})
			next_dac = edit_val[15:0];
	end

	// Reading, overrange and converter code
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reading <= 18'sh0;
			sig_over <= 1'b0;
			dig_over <= 1'b0;
			dac_code <= 16'h0000;
		end else begin
			sig_over <= signal_in < 16'(bgm_pkg::SIG_LOW) ||
				signal_in > 16'(bgm_pkg::SIG_HIGH);
			dig_over <= rd_full > 40'(bgm_pkg::DISP_MAX) ||
				rd_full < 40'(bgm_pkg::DISP_MIN);
			if (rd_full > 40'(bgm_pkg::DISP_MAX))
				reading <= 18'(bgm_pkg::DISP_MAX + 1);
			else if (rd_full < 40'(bgm_pkg::DISP_MIN))
				reading <= 18'(bgm_pkg::DISP_MIN - 1);
			else
				reading <= rd_full[17:0];
			dac_code <= next_dac;
		end
	end

	// ----------------------------------------
	// Display
	// ----------------------------------------
	bgm_pkg::bgm_disp_t next_disp;
	bgm_pkg::bgm_label_t step_lbl, val_lbl;
	localparam logic signed [17:0] VERSION_CODE_S = bgm_pkg::VERSION_CODE;
	always_comb begin
		step_lbl = bgm_pkg::LBL_NONE;
		val_lbl = edit_val[0] ? bgm_pkg::LBL_ON : bgm_pkg::LBL_OFF;
		case (state)
			bgm_pkg::S_CAL: step_lbl = bgm_pkg::LBL_CAL;
			bgm_pkg::S_OUTSEL: begin
				step_lbl = bgm_pkg::LBL_CAL;
				val_lbl = edit_val[0] ? bgm_pkg::LBL_OUT : bgm_pkg::LBL_INPUT;
			end
			bgm_pkg::S_ZERO: step_lbl = bgm_pkg::LBL_ZERO;
			bgm_pkg::S_SPAN: step_lbl = bgm_pkg::LBL_SPAN;
			bgm_pkg::S_ERR: step_lbl = bgm_pkg::LBL_ERR;
			bgm_pkg::S_BAR_HI: step_lbl = bgm_pkg::LBL_BAR_HIGH;
			bgm_pkg::S_BAR_LO: step_lbl = bgm_pkg::LBL_BAR_LOW;
			bgm_pkg::S_DEC: step_lbl = bgm_pkg::LBL_DEC_POINT;
			bgm_pkg::S_BRIGHT: step_lbl = bgm_pkg::LBL_BRIGHT;
			bgm_pkg::S_AN_HI: step_lbl = bgm_pkg::LBL_AN_HIGH;
			bgm_pkg::S_AN_LO: step_lbl = bgm_pkg::LBL_AN_LOW;
			bgm_pkg::S_CENTER: step_lbl = bgm_pkg::LBL_CENTER;
			bgm_pkg::S_OUT_LOW: step_lbl = bgm_pkg::LBL_CAL_LOW;
			bgm_pkg::S_OUT_HIGH: step_lbl = bgm_pkg::LBL_CAL_HIGH;
			default: ;
		endcase
		next_disp.all_on = state == bgm_pkg::S_LAMP;
		next_disp.over = sig_over || dig_over;
		next_disp.blank_digits = state == bgm_pkg::S_RUN &&
			(ctrl[bgm_pkg::CTRL_BLANK_BIT] || (next_disp.over && blink));
		next_disp.show_label = state == bgm_pkg::S_ERR ||
			(step_lbl != bgm_pkg::LBL_NONE && (!blink || toggle_st));
		next_disp.label = (blink && toggle_st) ? val_lbl : step_lbl;
		if (state == bgm_pkg::S_VER)
			next_disp.value = VERSION_CODE_S;
		else if (state == bgm_pkg::S_RUN || state == bgm_pkg::S_ERR)
			next_disp.value = reading;
		else
			next_disp.value = edit_val;
		next_disp.dp = decimal_point_select;
		next_disp.bright = brightness_level;
		next_disp.bars = (state == bgm_pkg::S_LAMP) ? 7'(bgm_pkg::BAR_SEGS) : bars;
		next_disp.bars_dark = state != bgm_pkg::S_LAMP && bar_over && blink;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			disp <= '0;
		else
			disp <= next_disp;
	end

	// ----------------------------------------
	// AHB-Lite register slave
	// ----------------------------------------
	wire ahb_take = hsel && hready && htrans[1];
	wire ahb_hit_lo = haddr[31:8] == 24'h000000;
	logic ahb_wr;
	logic [7:0] ahb_addr;
	logic [31:0] rd_mux;
	wire err_clr = ahb_wr && ahb_addr == bgm_pkg::REG_STATUS &&
		hwdata[bgm_pkg::STATUS_ERR_BIT];

	// Read mux; unmapped words read as zero
	always_comb begin
		rd_mux = 32'h00000000;
		if (!ahb_hit_lo)
			rd_mux = 32'h00000000;
		else if (haddr[7:0] == bgm_pkg::REG_CTRL)
			rd_mux = {30'h0, ctrl};
		else if (haddr[7:0] == bgm_pkg::REG_STATUS)
			rd_mux = {7'h0, state, 6'h0, disp.over, cal_err};
		else if (haddr[7:0] == bgm_pkg::REG_READING)
			rd_mux = 32'(reading);
		else if (haddr[7:0] == bgm_pkg::REG_DAC)
			rd_mux = {16'h0000, dac_code};
	end

	// Zero wait states, always OKAY
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h00000000;
			ahb_wr <= 1'b0;
			ahb_addr <= 8'h00;
		end else begin
			ahb_wr <= ahb_take && hwrite && ahb_hit_lo;
			if (ahb_take)
				ahb_addr <= haddr[7:0];
			if (ahb_take && !hwrite)
				hrdata <= rd_mux;
		end
	end

	// Control bits steer lockout and digit blanking
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			ctrl <= 2'h0;
		else if (ahb_wr && ahb_addr == bgm_pkg::REG_CTRL)
			ctrl <= hwdata[1:0];
	end

	// Sticky calibration error; a new failure beats a clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			cal_err <= 1'b0;
		else if (state == bgm_pkg::S_SPAN && ev_prog && !cal_ok)
			cal_err <= 1'b1;
		else if (err_clr)
			cal_err <= 1'b0;
	end
endmodule : bgm_top
`default_nettype wire

// ### common/bgm_pkg.sv
// Constants and types shared by the bargraph meter controller
package bgm_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int TICK_US = 1000;
	localparam int TICK_CYCLES = TICK_US * 1000 / CLK_PERIOD_NS;
	localparam int LAMP_MS = 3000;
	localparam int VERSION_MS = 2000;
	localparam int TIMEOUT_MS = 15000;
	localparam int ERROR_MS = 2000;
	localparam int BLINK_MS = 250;
	localparam int DEBOUNCE_MS = 20;
	// ----------------------------------------
	// Limits of readings and spans
	// ----------------------------------------
	localparam int DISP_MIN = -1999;
	localparam int DISP_MAX = 9999;
	localparam int DISP_SPAN = 12000;
	localparam int CAL_MIN_DIFF = 1000;
	localparam int SIG_LOW = -1000;
	localparam int SIG_HIGH = 2000;
	localparam int SIG_WINDOW = SIG_HIGH - SIG_LOW;
	localparam int BAR_SEGS = 101;
	localparam int BAR_SPAN_MIN = 100;
	localparam int BRIGHT_MAX = 4;
	localparam int DP_MAX = 3;
	localparam int DAC_MAX = 65535;
	localparam int DAC_STEP = 64;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam int CAL_LO_SIG_RST = 0;
	localparam int CAL_HI_SIG_RST = 1000;
	localparam int CAL_LO_RD_RST = 0;
	localparam int CAL_HI_RD_RST = 1000;
	localparam int BAR_LO_RST = 0;
	localparam int BAR_HI_RST = 1000;
	localparam int AN_LO_RST = 0;
	localparam int AN_HI_RST = 1000;
	localparam int OUT_LO_RST = 4096;
	localparam int OUT_HI_RST = 57344;
	localparam int BRIGHT_RST = 4;
	// Version shown at power-up; value is arbitrary
	localparam logic [17:0] VERSION_CODE = 18'h00012;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_READING = 8'h08;
	localparam logic [7:0] REG_DAC = 8'h0C;
	localparam int CTRL_LOCK_BIT = 0;
	localparam int CTRL_BLANK_BIT = 1;
	localparam int STATUS_ERR_BIT = 0;
	localparam int STATUS_OVER_BIT = 1;
	localparam int STATUS_STATE_POS = 8;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [16:0] {
		S_LAMP = 17'h00001, S_VER = 17'h00002, S_RUN = 17'h00004,
		S_CAL = 17'h00008, S_OUTSEL = 17'h00010, S_ZERO = 17'h00020,
		S_SPAN = 17'h00040, S_ERR = 17'h00080, S_BAR_HI = 17'h00100,
		S_BAR_LO = 17'h00200, S_DEC = 17'h00400, S_BRIGHT = 17'h00800,
		S_AN_HI = 17'h01000, S_AN_LO = 17'h02000, S_CENTER = 17'h04000,
		S_OUT_LOW = 17'h08000, S_OUT_HIGH = 17'h10000
	} bgm_state_t;
	typedef enum logic [4:0] {
		LBL_NONE = 5'h00, LBL_CAL = 5'h01, LBL_ON = 5'h02, LBL_OFF = 5'h03,
		LBL_OUT = 5'h04, LBL_INPUT = 5'h05, LBL_ZERO = 5'h06, LBL_SPAN = 5'h07,
		LBL_ERR = 5'h08, LBL_BAR_HIGH = 5'h09, LBL_BAR_LOW = 5'h0A,
		LBL_DEC_POINT = 5'h0B, LBL_BRIGHT = 5'h0C, LBL_AN_HIGH = 5'h0D,
		LBL_AN_LOW = 5'h0E, LBL_CENTER = 5'h0F, LBL_CAL_LOW = 5'h10,
		LBL_CAL_HIGH = 5'h11
	} bgm_label_t;
	typedef struct packed {
		logic all_on;
		logic blank_digits;
		logic show_label;
		bgm_label_t label;
		logic signed [17:0] value;
		logic [1:0] dp;
		logic [2:0] bright;
		logic [6:0] bars;
		logic bars_dark;
		logic over;
	} bgm_disp_t;
endpackage : bgm_pkg

// ### bench/bgm_cond_model.sv
// Model of the plug-in conditioner and output module
`timescale 1ns/1ns
`default_nettype none
module bgm_cond_model (
	input wire logic clk,
	input wire logic signed [15:0] level_mv,
	input wire logic fitted,
	output logic signed [15:0] signal_in,
	output logic analog_present
);
	// Reading follows the applied level one clock late, like a sampled front end
	always_ff @(posedge clk) begin
		signal_in <= level_mv;
	end
	// Output module fitted or not is a fixed strap
	assign analog_present = fitted;
endmodule : bgm_cond_model
`default_nettype wire

// ### bench/bgm_sva.sv
// Checker of bus, display and overrange relations
`timescale 1ns/1ns
`default_nettype none
module bgm_sva (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic signed [15:0] signal_in,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire bgm_pkg::bgm_disp_t disp
);
	// ----
	// Sequences
	// ----
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence rd_take;
		hsel && hready && htrans[1] && !hwrite;
	endsequence
	// Six samples let the reading pipeline catch up
	sequence sig_out;
		(signal_in > bgm_pkg::SIG_HIGH || signal_in < bgm_pkg::SIG_LOW) [*6];
	endsequence
	// ----
	// Assertions
	// ----
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus answer not ready or not okay");
	a_unmapped_zero: assert property (rd_take ##0 haddr[31:8] != 24'h0 |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_rdata_holds: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
		else $error("read data moved without a read");
	a_lamp_full: assert property (disp.all_on |-> disp.bars == 7'h65)
		else $error("lamp test without full bar");
	a_bars_limit: assert property (disp.bars <= bgm_pkg::BAR_SEGS)
		else $error("bar count above full scale");
	a_bright_limit: assert property (disp.bright <= bgm_pkg::BRIGHT_MAX)
		else $error("brightness above top level");
	a_dark_over: assert property (disp.bars_dark |-> disp.bars == 7'h65)
		else $error("flash off phase below full bar");
	a_window_over: assert property (sig_out |-> disp.over)
		else $error("signal outside window without overrange");
endmodule : bgm_sva
bind bgm_top bgm_sva u_sva (.clk, .rst_n, .signal_in, .hsel, .haddr, .htrans, .hwrite,
	.hready, .hreadyout, .hresp, .hrdata, .disp);
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking bench of the bargraph meter controller
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	// ----
	// Signals and instances
	// ----
	logic clk, rst_n, btn_prog, btn_up, btn_down, hsel, hwrite, hreadyout, hresp, fitted;
	logic analog_present;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [15:0] dac_code;
	logic [31:0] haddr, hwdata, hrdata, d;
	logic signed [15:0] mv, signal_in;
	bgm_pkg::bgm_disp_t disp;
	int miscompares = 0;
	int total_checks = 0;
	// Levels, then expected bars, converter code and overrange
	int sv[6] = '{0, 500, 1000, 1500, -100, 2100};
	int bv[6] = '{0, 50, 101, 101, 0, 101};
	int dv[6] = '{4096, 30720, 57344, 65535, 4096, 65535};
	int ov[6] = '{0, 0, 0, 0, 0, 1};
	bgm_cond_model cond (.clk, .level_mv(mv), .fitted, .signal_in, .analog_present);
	// Short tick keeps the timed menus within the run length
	bgm_top #(.TICK_CYCLES(4)) dut (.clk, .rst_n, .btn_prog, .btn_up, .btn_down, .signal_in,
		.analog_present, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .disp, .dac_code);
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// ----
	// Tasks
	// ----
	task summarize;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : summarize
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	// Bounded wait for hready; a stuck slave ends the run
	task wait_rdy;
		int n;
		n = 0;
		@(posedge clk);
		while (hreadyout !== 1'b1) begin
			n++;
			if (n > 50) begin
				miscompares++;
				summarize();
			end
			@(posedge clk);
		end
	endtask : wait_rdy
	task bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		d = hrdata;
	endtask : bus
	task st(input bgm_pkg::bgm_state_t s);
		bus(1'b0, 32'h4, 32'h0);
		check("state", d & 32'h01FFFF00, 32'(s) << 8);
	endtask : st
	// Held past the debounce time, then released past it
	task press(input logic [2:0] b);
		{btn_prog, btn_up, btn_down} <= b;
		cyc(100);
		{btn_prog, btn_up, btn_down} <= 3'h0;
		cyc(100);
	endtask : press
	// ----
	// Main sequence
	// ----
	initial begin
		{rst_n, btn_prog, btn_up, btn_down, hsel, hwrite, fitted} = 7'h00;
		htrans = 2'h0;
		hsize = 3'h2;
		haddr = 32'h0;
		hwdata = 32'h0;
		mv = 16'h0000;
		cyc(6);
		rst_n <= 1'b1;
		cyc(2);
		check("lamp", disp.all_on, 32'h1);
		cyc(11700);
		st(bgm_pkg::S_LAMP);
		cyc(500);
		st(bgm_pkg::S_VER);
		check("version", disp.value, 32'h12);
		cyc(8000);
		st(bgm_pkg::S_RUN);
		// Scaling of reading, bars and converter code
		for (int i = 0; i < 6; i++) begin
			mv <= 16'(sv[i]);
			cyc(20);
			bus(1'b0, 32'h8, 32'h0);
			check("reading", d, 32'(sv[i]));
			check("bars", disp.bars, bv[i]);
			check("dac", dac_code, dv[i]);
			check("over", disp.over, ov[i]);
		end
		bus(1'b0, 32'h100, 32'h0);
		check("unmapped", d, 32'h0);
		bus(1'b1, 32'h0, 32'h2);
		cyc(4);
		check("blank", disp.blank_digits, 32'h1);
		check("point", disp.dp, 32'h0);
		// Locked panel refuses the entry combination
		mv <= 16'h0000;
		bus(1'b1, 32'h0, 32'h1);
		press(3'h6);
		st(bgm_pkg::S_RUN);
		bus(1'b1, 32'h0, 32'h0);
		// Calibration with signals too close fails and keeps old scaling
		press(3'h6);
		st(bgm_pkg::S_CAL);
		press(3'h2);
		press(3'h4);
		st(bgm_pkg::S_ZERO);
		press(3'h4);
		st(bgm_pkg::S_SPAN);
		mv <= 16'h01F4;
		press(3'h4);
		st(bgm_pkg::S_ERR);
		check("cal error", d[0], 32'h1);
		check("err label", disp.label, 32'h8);
		check("err shown", disp.show_label, 32'h1);
		cyc(8100);
		st(bgm_pkg::S_RUN);
		bus(1'b0, 32'h8, 32'h0);
		check("old scaling", d, 32'h1F4);
		// Good calibration, then the display menu in order
		mv <= 16'h0000;
		press(3'h6);
		press(3'h2);
		press(3'h4);
		press(3'h4);
		mv <= 16'h03E8;
		press(3'h4);
		st(bgm_pkg::S_BAR_HI);
		press(3'h4);
		st(bgm_pkg::S_BAR_LO);
		press(3'h4);
		st(bgm_pkg::S_DEC);
		press(3'h4);
		st(bgm_pkg::S_BRIGHT);
		press(3'h1);
		press(3'h4);
		st(bgm_pkg::S_CENTER);
		press(3'h4);
		st(bgm_pkg::S_RUN);
		check("bright", disp.bright, 32'h3);
		// Idle timeout in the brightness step drops the edit
		press(3'h6);
		repeat (4) press(3'h4);
		press(3'h2);
		cyc(60100);
		st(bgm_pkg::S_RUN);
		check("bright kept", disp.bright, 32'h3);
		summarize();
	end
endmodule : tb_top
`default_nettype wire
